// File: float_add_op_align_pkg.sv
// constants and types for the floating add alignment datapath
package float_add_op_align_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] EXP_A_OFS = 8'h08;
  localparam logic [7:0] EXP_B_OFS = 8'h0c;
  localparam logic [7:0] OPA_HI_OFS = 8'h10;
  localparam logic [7:0] OPA_LO_OFS = 8'h14;
  localparam logic [7:0] OPB_HI_OFS = 8'h18;
  localparam logic [7:0] OPB_LO_OFS = 8'h1c;
  localparam logic [7:0] RES_HI_OFS = 8'h20;
  localparam logic [7:0] RES_LO_OFS = 8'h24;
  localparam logic [7:0] ZTEST_OFS = 8'h28;
  localparam logic [7:0] SP_OFS = 8'h2c;
  localparam logic [7:0] PC_OFS = 8'h30;
  localparam logic [7:0] UPTR_OFS = 8'h34;
  // ---------------------------------------------------------------
  // field positions and constants
  // ---------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SUB_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_NEG_BIT = 2;
  localparam int ST_ABORT_BIT = 3;
  localparam int ST_EXPZ_BIT = 4;
  localparam int UPTR_REDIRECT_BIT = 5;
  localparam int UPTR_STORE_BIT = 8;
  localparam logic [7:0] RANGE_LIMIT = 8'h18;      // octal 30
  localparam logic [15:0] SP_BACKUP = 16'h0006;    // octal 6
  localparam logic [15:0] PC_BACKUP = 16'h0002;
  localparam logic [8:0] UPTR_ADD30 = 9'h1cf;      // octal 717
  localparam logic [8:0] UPTR_ADD27 = 9'h1cb;      // octal 713
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [8:0] UPTR_RESET = 9'h100;

  typedef enum logic [3:0] {
    S_IDLE, S_SIGN, S_SHLO, S_SHHI, S_EQTEST, S_SHRIGHT, S_ADDLO, S_ADDHI,
    S_ZTEST, S_NEGATE, S_FINAL, S_ABORT
  } seq_state_type;
endpackage : float_add_op_align_pkg

// File: float_add_align_datapath.sv
// floating add/subtract alignment, addition, sign fix and abort datapath
`timescale 1ns/1ps
// Operation
// - larger exponent is kept in the second operand exponent register for result
// - mantissas count 24 significant bits including hidden one
// - difference above octal 30 skips shifting, larger operand passes unchanged
// - larger low word doubled, carry-out saved as second rounding bit
// - larger high word doubled with saved carry in, one 32-bit shift
// - shift count decremented in the step that tests it, after sampling
// - smaller operand right shift replicates high word sign bit
// - equal exponents: smaller operand shifted left once, zero fill
// - difference of exactly one: no right shift, straight to addition
// - otherwise right shift smaller operand difference minus one times
// - add low words first and store, then add high words
// - high answer sign bit copied to negative status flag
// - high answer ORed with low answer into zero-test register
// - negative answer: two's complement low and high in one step, repeat zero test
// - positive answer shifted right once before normalization
// - at test points a latched bus request forces pointer bit 5
// - each right-shift pass tests for bus request and aborts
// - on bus request abort, restore stack pointer for restart
// - abort subtracts octal 6 from stack pointer
// - abort clears pointer bit 8, decrements program counter by 2
// - subtraction inverts subtrahend sign first, then follows add flow
module float_add_align_datapath
  import float_add_op_align_pkg::*;
(
  input wire logic ref_clk,           // 250 MHz clock
  input wire logic rst_n,             // async reset, active low
  input wire logic psel,              // apb select
  input wire logic penable,           // apb access phase
  input wire logic pwrite,            // apb direction
  input wire logic [7:0] paddr,       // apb byte address
  input wire logic [31:0] pwdata,     // apb write data
  output logic [31:0] prdata,         // apb read data
  output logic pready,                // apb ready
  output logic pslverr,               // apb error for unmapped address
  input wire logic nonprocessor_request, // bus request from host, same clock
  output logic done                   // answer ready for normalize stage
);
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic wrEn;
  logic rdEn;
  logic mapped;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= UPTR_OFS);
  assign pslverr = psel && penable && !mapped;

  seq_state_type state;
  logic subOp;
  logic [7:0] expA;
  logic [7:0] expB;
  logic [31:0] opAHi;
  logic [31:0] opALo;
  logic [31:0] opBHi;
  logic [31:0] opBLo;
  logic [7:0] shiftCount;
  logic [7:0] origDiff;
  logic [31:0] high_shift_word_reg;
  logic [31:0] low_shift_word_reg;
  logic [31:0] bigHi;
  logic [31:0] bigLo;
  logic carrySave;
  logic [31:0] zeroTest;
  logic negative_status_flag;
  logic exponent_zero_flag;
  logic abortFlag;
  logic busReqLatch;
  logic [15:0] stack_pointer_reg;
  logic [15:0] progCounter;
  logic [8:0] microprogram_pointer;
  logic startPulse;

  assign startPulse = wrEn && (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT] && (state == S_IDLE);

  // subtrahend sign flips before the exchange, so it follows operand b wherever it lands
  logic [31:0] subHi;
  assign subHi = subOp ? ~opBHi + 32'h1 : opBHi;

  // ---------------------------------------------------------------
  // operand and exponent registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      subOp <= 1'b0;
      expA <= 8'h00;
      expB <= 8'h00;
      opAHi <= 32'h0;
      opALo <= 32'h0;
      opBHi <= 32'h0;
      opBLo <= 32'h0;
    end else if (state == S_IDLE && wrEn) begin
      unique case (paddr)
        CTRL_OFS: subOp <= pwdata[CTRL_SUB_BIT];
        EXP_A_OFS: expA <= pwdata[7:0];
        EXP_B_OFS: expB <= pwdata[7:0];
        OPA_HI_OFS: opAHi <= pwdata;
        OPA_LO_OFS: opALo <= pwdata;
        OPB_HI_OFS: opBHi <= pwdata;
        OPB_LO_OFS: opBLo <= pwdata;
        default: ;
      endcase
    end else if (state == S_SIGN) begin
      if (expA > expB) begin
        // operand exchange leaves the larger exponent in the second slot
        expB <= expA;
        expA <= expB;
        opAHi <= subHi;
        opALo <= opBLo;
        opBHi <= opAHi;
        opBLo <= opALo;
      end else begin
        opBHi <= subHi;
      end
    end else if (state == S_ABORT) begin
      subOp <= subOp;
    end
  end

  // ---------------------------------------------------------------
  // bus request latch: sampled in the S_SHHI range test and at the count-zero test points
  // ---------------------------------------------------------------
  logic testPoint;
  assign testPoint = (state == S_EQTEST) || (state == S_SHRIGHT) || (state == S_SHHI);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busReqLatch <= 1'b0;
    end else if (state == S_ABORT || state == S_IDLE) begin
      busReqLatch <= 1'b0;
    end else if (testPoint) begin
      busReqLatch <= nonprocessor_request;
    end
  end

  logic reqNow;
  assign reqNow = busReqLatch || nonprocessor_request;

  // ---------------------------------------------------------------
  // sequencer and datapath
  // ---------------------------------------------------------------
  logic [32:0] loSum;
  logic [31:0] hiSum;
  logic [31:0] negLo;
  logic negCarry;
  assign loSum = {1'b0, bigLo} + {1'b0, low_shift_word_reg};
  assign hiSum = bigHi + high_shift_word_reg + {31'h0, carrySave};
  assign negLo = ~low_shift_word_reg + 32'h1;
  assign negCarry = (low_shift_word_reg == 32'h0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      shiftCount <= 8'h00;
      origDiff <= 8'h00;
      bigHi <= 32'h0;
      bigLo <= 32'h0;
      carrySave <= 1'b0;
      high_shift_word_reg <= 32'h0;
      low_shift_word_reg <= 32'h0;
      zeroTest <= 32'h0;
      negative_status_flag <= 1'b0;
      exponent_zero_flag <= 1'b0;
      abortFlag <= 1'b0;
      done <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (startPulse) begin
            done <= 1'b0;
            abortFlag <= 1'b0;
            state <= S_SIGN;
          end
        end
        S_SIGN: begin
          shiftCount <= (expA > expB) ? expA - expB : expB - expA;
          origDiff <= (expA > expB) ? expA - expB : expB - expA;
          exponent_zero_flag <= (expA == expB);
          state <= S_SHLO;
        end
        S_SHLO: begin
          // smaller operand into the shift pair; larger low word doubled, carry-out saved
          high_shift_word_reg <= opAHi;
          low_shift_word_reg <= opALo;
          bigHi <= opBHi;
          {carrySave, bigLo} <= {opBLo, 1'b0};
          shiftCount <= shiftCount - 8'h01;
          state <= S_SHHI;
        end
        S_SHHI: begin
          bigHi <= {bigHi[30:0], carrySave};
          carrySave <= 1'b0;
          // mantissa range is 24 bits; beyond it no alignment helps
          if (origDiff > RANGE_LIMIT) begin
            high_shift_word_reg <= 32'h0;
            low_shift_word_reg <= 32'h0;
            state <= S_ADDLO;
          end else begin
            state <= S_EQTEST;
          end
        end
        S_EQTEST: begin
          if (reqNow) begin
            state <= S_ABORT;
          end else if (exponent_zero_flag) begin
            {high_shift_word_reg, low_shift_word_reg} <=
              {high_shift_word_reg[30:0], low_shift_word_reg, 1'b0};
            state <= S_ADDLO;
          end else if (shiftCount == 8'h00) begin
            state <= S_ADDLO;
          end else begin
            state <= S_SHRIGHT;
          end
        end
        S_SHRIGHT: begin
          if (reqNow) begin
            state <= S_ABORT;
          end else begin
            {high_shift_word_reg, low_shift_word_reg} <=
              {high_shift_word_reg[31], high_shift_word_reg, low_shift_word_reg[31:1]};
            shiftCount <= shiftCount - 8'h01;
            if (shiftCount == 8'h01) begin
              state <= S_ADDLO;
            end
          end
        end
        S_ADDLO: begin
          low_shift_word_reg <= loSum[31:0];
          carrySave <= loSum[32];
          state <= S_ADDHI;
        end
        S_ADDHI: begin
          high_shift_word_reg <= hiSum;
          negative_status_flag <= hiSum[31];
          state <= S_ZTEST;
        end
        S_ZTEST: begin
          zeroTest <= high_shift_word_reg | low_shift_word_reg;
          state <= high_shift_word_reg[31] ? S_NEGATE : S_FINAL;
        end
        S_NEGATE: begin
          low_shift_word_reg <= negLo;
          high_shift_word_reg <= ~high_shift_word_reg + {31'h0, negCarry};
          state <= S_ZTEST;
        end
        S_FINAL: begin
          {high_shift_word_reg, low_shift_word_reg} <=
            {1'b0, high_shift_word_reg, low_shift_word_reg[31:1]};
          done <= 1'b1;
          state <= S_IDLE;
        end
        S_ABORT: begin
          abortFlag <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // stack pointer, program counter and microprogram pointer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_reg <= SP_RESET;
      progCounter <= PC_RESET;
    end else if (state == S_ABORT) begin
      stack_pointer_reg <= stack_pointer_reg - SP_BACKUP;
      progCounter <= progCounter - PC_BACKUP;
    end else if (state == S_IDLE && wrEn && paddr == SP_OFS) begin
      stack_pointer_reg <= pwdata[15:0];
    end else if (state == S_IDLE && wrEn && paddr == PC_OFS) begin
      progCounter <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      microprogram_pointer <= UPTR_RESET;
    end else if (state == S_EQTEST && reqNow) begin
      microprogram_pointer <= (exponent_zero_flag || shiftCount == 8'h00) ?
        (UPTR_ADD30 | 9'h020) : (UPTR_ADD27 | 9'h020);
    end else if (state == S_SHRIGHT && reqNow) begin
      microprogram_pointer <= UPTR_ADD27 | 9'h020;
    end else if (state == S_ABORT) begin
      microprogram_pointer[UPTR_STORE_BIT] <= 1'b0;
    end else if (startPulse) begin
      microprogram_pointer <= UPTR_RESET;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        CTRL_OFS: prdata <= {30'h0, subOp, 1'b0};
        STATUS_OFS: prdata <= {27'h0, exponent_zero_flag, abortFlag,
                               negative_status_flag, done, state != S_IDLE};
        EXP_A_OFS: prdata <= {24'h0, expA};
        EXP_B_OFS: prdata <= {24'h0, expB};
        OPA_HI_OFS: prdata <= opAHi;
        OPA_LO_OFS: prdata <= opALo;
        OPB_HI_OFS: prdata <= opBHi;
        OPB_LO_OFS: prdata <= opBLo;
        RES_HI_OFS: prdata <= high_shift_word_reg;
        RES_LO_OFS: prdata <= low_shift_word_reg;
        ZTEST_OFS: prdata <= zeroTest;
        SP_OFS: prdata <= {16'h0, stack_pointer_reg};
        PC_OFS: prdata <= {16'h0, progCounter};
        UPTR_OFS: prdata <= {23'h0, microprogram_pointer};
        default: prdata <= 32'h0;
      endcase
    end
  end
endmodule : float_add_align_datapath

// File: float_add_op_host_model.sv
// host bus logic model that raises a nonprocessor request toward the datapath
`timescale 1ns/1ps
module float_add_op_host_model #(
  parameter int HOLD = 30
) (
  input wire logic ref_clk, // processor clock
  input wire logic rst_n, // async reset, active low
  input wire logic busCycle, // bus data cycle sync from a requesting master
  output logic nonprocessor_request // latched request toward the datapath
);
  int unsigned holdLeft;
  // request stays raised for HOLD cycles after the bus cycle; a short hold would miss the shift loop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdLeft <= 0;
      nonprocessor_request <= 1'b0;
    end else if (busCycle) begin
      holdLeft <= HOLD;
      nonprocessor_request <= 1'b1;
    end else if (holdLeft != 0) begin
      holdLeft <= holdLeft - 1;
      nonprocessor_request <= (holdLeft > 1);
    end
  end
endmodule : float_add_op_host_model

// File: float_add_align_datapath_asserts.sv
// port checker for the floating add alignment datapath
`timescale 1ns/1ps
module float_add_align_datapath_asserts
  import float_add_op_align_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic nonprocessor_request, // bus request
  input wire logic done // answer ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic startWr;
  logic acc;
  assign acc = psel && penable;
  assign startWr = acc && pwrite && paddr == CTRL_OFS && pwdata[CTRL_START_BIT];

  a_ready_always: assert property (pready) else $error("pready low");
  a_bad_addr_err: assert property (acc && (paddr > UPTR_OFS || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
  a_good_addr_ok: assert property (acc && paddr <= UPTR_OFS && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged");
  a_bad_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_data_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_start_clears_done: assert property (startWr |-> ##[1:2] !done)
    else $error("done not cleared by start");
  a_done_not_early: assert property (startWr |-> ##2 !done [*3])
    else $error("done too early");
  a_done_in_time: assert property (startWr && !nonprocessor_request |->
    ##[4:60] (done || nonprocessor_request)) else $error("done late");
  a_done_level_holds: assert property (done && !startWr |=> done)
    else $error("done dropped");

  cover property ($rose(done));
  cover property (acc && pslverr);
  cover property (startWr ##[1:20] nonprocessor_request);
endmodule : float_add_align_datapath_asserts

bind float_add_align_datapath float_add_align_datapath_asserts chk (.ref_clk(ref_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nonprocessor_request(nonprocessor_request), .done(done));

// File: float_add_align_datapath_tb.sv
// self-checking testbench for the floating add alignment datapath
`timescale 1ns/1ps
module float_add_align_datapath_tb
  import float_add_op_align_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic nonprocessor_request;
  logic done;
  logic busCycle = 1'b0;
  int mismatches = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;

  always #2 ref_clk = ~ref_clk;

  float_add_align_datapath uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nonprocessor_request(nonprocessor_request),
    .done(done));
  float_add_op_host_model host (.ref_clk(ref_clk), .rst_n(rst_n), .busCycle(busCycle),
    .nonprocessor_request(nonprocessor_request));

  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one idle edge before each setup so psel is never lowered and raised in one step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic start_op(input logic [31:0] ea, eb, ahi, alo, bhi, blo, input logic sub);
    apb(EXP_A_OFS, 1'b1, ea, rd, err);
    apb(EXP_B_OFS, 1'b1, eb, rd, err);
    apb(OPA_HI_OFS, 1'b1, ahi, rd, err);
    apb(OPA_LO_OFS, 1'b1, alo, rd, err);
    apb(OPB_HI_OFS, 1'b1, bhi, rd, err);
    apb(OPB_LO_OFS, 1'b1, blo, rd, err);
    apb(CTRL_OFS, 1'b1, {30'h0, sub, 1'b1}, rd, err);
  endtask : start_op

  task automatic run_op(input logic [31:0] ea, eb, ahi, alo, bhi, blo, input logic sub);
    logic [63:0] a, b, s;
    logic neg;
    int d;
    a = {ahi, alo};
    b = {sub ? -bhi : bhi, blo};
    if (ea > eb) begin
      s = a;
      a = b;
      b = s;
    end
    d = (ea > eb) ? ea - eb : eb - ea;
    b = b << 1;
    if (d == 0) a = a << 1;
    else a = $signed(a) >>> (d - 1);
    s = (d > 24) ? b : a + b;
    neg = s[63];
    if (neg) s = -s;
    start_op(ea, eb, ahi, alo, bhi, blo, sub);
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge ref_clk);
    check("done", 32'h1, {31'h0, done});
    apb(ZTEST_OFS, 1'b0, 32'h0, rd, err);
    check("zero test", s[63:32] | s[31:0], rd);
    s = s >> 1;
    apb(RES_HI_OFS, 1'b0, 32'h0, rd, err);
    check("result hi", s[63:32], rd);
    apb(RES_LO_OFS, 1'b0, 32'h0, rd, err);
    check("result lo", s[31:0], rd);
    apb(STATUS_OFS, 1'b0, 32'h0, rd, err);
    check("status", {27'h0, d == 0, 1'b0, neg, 2'b10}, rd & 32'h1f);
    apb(EXP_B_OFS, 1'b0, 32'h0, rd, err);
    check("exponent b", (ea > eb) ? ea : eb, rd);
  endtask : run_op

  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    run_op(5, 5, 32'h00400000, 0, 32'h00400000, 0, 0);
    run_op(5, 6, 32'h00400000, 0, 32'h00400000, 0, 0);
    run_op(2, 5, 32'hf0000000, 0, 32'h00400000, 0, 0);
    run_op(0, 24, 32'h00400000, 0, 32'h00400000, 0, 0);
    run_op(0, 25, 32'h00400000, 0, 32'h00400000, 0, 0);
    run_op(7, 5, 32'h00400000, 0, 32'h00200000, 0, 0);
    run_op(5, 5, 32'h00400000, 0, 32'h00800000, 0, 1);
    run_op(7, 5, 32'h00400000, 0, 32'h00200000, 0, 1);
    apb(8'h38, 1'b0, 32'h0, rd, err);
    check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    apb(8'h02, 1'b1, 32'h1, rd, err);
    check("unaligned err", 32'h1, {31'h0, err});
    // request arrives while the long right-shift loop is running
    start_op(0, 20, 32'h00400000, 0, 32'h00400000, 0, 0);
    repeat (6) @(posedge ref_clk);
    busCycle <= 1'b1;
    @(posedge ref_clk);
    busCycle <= 1'b0;
    rd = 32'h0;
    for (int i = 0; i < 60 && rd[ST_ABORT_BIT] !== 1'b1; i++) apb(STATUS_OFS, 1'b0, 0, rd, err);
    check("abort", 32'h1, {31'h0, rd[ST_ABORT_BIT]});
    apb(SP_OFS, 1'b0, 32'h0, rd, err);
    check("stack pointer", {16'h0, SP_RESET - SP_BACKUP}, {16'h0, rd[15:0]});
    apb(PC_OFS, 1'b0, 32'h0, rd, err);
    check("program counter", {16'h0, PC_RESET - PC_BACKUP}, {16'h0, rd[15:0]});
    apb(UPTR_OFS, 1'b0, 32'h0, rd, err);
    check("micro pointer", {23'h0, ((UPTR_ADD27 | 9'h020) & 9'h0ff)}, rd);
    // request already pending when the equal-exponent test point is reached
    start_op(5, 5, 32'h00400000, 0, 32'h00400000, 0, 0);
    busCycle <= 1'b1;
    @(posedge ref_clk);
    busCycle <= 1'b0;
    rd = 32'h0;
    for (int i = 0; i < 60 && rd[ST_ABORT_BIT] !== 1'b1; i++) apb(STATUS_OFS, 1'b0, 0, rd, err);
    check("abort equal", 32'h1, {31'h0, rd[ST_ABORT_BIT]});
    apb(SP_OFS, 1'b0, 32'h0, rd, err);
    check("stack pointer 2", {16'h0, SP_RESET - SP_BACKUP - SP_BACKUP}, rd);
    apb(PC_OFS, 1'b0, 32'h0, rd, err);
    check("program counter 2", {16'h0, PC_RESET - PC_BACKUP - PC_BACKUP}, rd);
    apb(UPTR_OFS, 1'b0, 32'h0, rd, err);
    check("micro pointer 2", {23'h0, ((UPTR_ADD30 | 9'h020) & 9'h0ff)}, rd);
    report_and_stop();
  end
endmodule : float_add_align_datapath_tb
